// ==== logic/mpc_pkg.sv ====
package mpc_pkg;

	localparam logic [8:0]  ADDR_CONN     = 9'h1F0;
	localparam logic [8:0]  ADDR_CD_ON    = 9'h1F4;
	localparam logic [8:0]  ADDR_CD_OFF   = 9'h1F5;
	localparam logic [8:0]  ADDR_EYE_MAX  = 9'h1F6;
	localparam logic [8:0]  ADDR_MODEM    = 9'h1F7;
	localparam logic [8:0]  ADDR_MISC     = 9'h1FA;
	localparam logic [8:0]  ADDR_TONE     = 9'h1FC;
	localparam logic [8:0]  ADDR_BUF      = 9'h1FD;

	localparam logic [15:0] RST_CONN      = 16'h0000;
	// Linear codes for -43 dBm and -48 dBm on the 32767 full scale.
	localparam logic [15:0] RST_CD_ON     = 16'h00E8;
	localparam logic [15:0] RST_CD_OFF    = 16'h0082;
	localparam logic [15:0] RST_EYE_MAX   = 16'h0400;
	localparam logic [15:0] RST_MODEM     = 16'h0000;
	localparam logic [15:0] RST_MISC      = 16'h0000;
	localparam logic [15:0] RST_TONE      = 16'h0080;
	localparam logic [15:0] RST_BUF       = 16'h0000;

	localparam int BUF_HDLC       = 7;
	localparam int BUF_SCR_OFF    = 3;
	localparam int BUF_TX_MARKS   = 2;
	localparam int BUF_DSCR_OFF   = 1;
	localparam int BUF_RX_MARKS   = 0;
	localparam int TONE_A_HIT     = 15;
	localparam int TONE_B_HIT     = 14;
	localparam int TONE_CASCADE   = 13;
	localparam int TONE_MULTITONE = 7;
	localparam int TONE_SQR_BYP   = 5;
	localparam int TONE_TIMED     = 4;
	localparam int MISC_GAIN_FRZ  = 14;
	localparam int MISC_GUARD_EN  = 9;
	localparam int MISC_GUARD_SEL = 8;
	localparam int MISC_EYE_EXC   = 4;
	localparam int MISC_EQ_FRZ    = 3;
	localparam int MISC_SYM_SPACE = 2;
	localparam int MODEM_RETRAIN  = 11;
	localparam int MODEM_SEIZE    = 2;

	localparam logic [6:0]  MODE_STANDBY  = 7'h00;
	localparam logic [6:0]  MODE_DIAL     = 7'h03;
	localparam logic [6:0]  MODE_V22BIS   = 7'h08;
	localparam logic [6:0]  MODE_V22      = 7'h09;
	localparam logic [6:0]  MODE_212      = 7'h0B;
	localparam logic [6:0]  MODE_V21      = 7'h10;
	localparam logic [6:0]  MODE_103      = 7'h11;
	localparam logic [6:0]  MODE_V23_FWD  = 7'h13;
	localparam logic [6:0]  MODE_V23_REV  = 7'h14;

	localparam logic [2:0]  TXSEQ_SILENT  = 3'h0;
	localparam logic [2:0]  TXSEQ_DATA    = 3'h5;
	localparam logic [2:0]  TXSEQ_DATA_HI = 3'h6;
	localparam logic [2:0]  TXSEQ_TONE    = 3'h7;

	typedef enum logic [1:0] {
		MPC_TXA_SILENT = 2'b00,
		MPC_TXA_DATA   = 2'b01,
		MPC_TXA_TONE   = 2'b10,
		MPC_TXA_TRAIN  = 2'b11
	} mpc_txa_e;

	typedef enum logic {
		MPC_RT_IDLE = 1'b0,
		MPC_RT_BUSY = 1'b1
	} mpc_rt_e;

	typedef struct packed {
		mpc_txa_e   action;
		logic       scrambler_on;
		logic       force_marks;
		logic       guard_on;
		logic       guard_1800;
	} mpc_tx_s;

	typedef struct packed {
		logic       scrambler_on;
		logic       force_marks;
		logic       hdlc;
	} mpc_rx_s;

	typedef struct packed {
		logic       active;
		logic       multitone;
		logic       timed;
		logic [3:0] digit;
	} mpc_dial_s;

	typedef struct packed {
		logic       cascade;
		logic       squarer_bypass;
		logic       gain_freeze;
		logic       eq_freeze;
		logic       eq_symbol_spaced;
	} mpc_dsp_s;

endpackage

// ==== logic/mpc_baud_shadow.sv ====
// Holds the working copy of a threshold word; it follows the host copy
// only at a baud boundary so a detector never sees a threshold change mid-baud.
module mpc_baud_shadow #(
	parameter logic [15:0] RESET_VALUE = 16'h0000
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        tick_i,
	input  wire logic [15:0] d_i,
	output logic      [15:0] q_o
);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q_o <= RESET_VALUE;
		end else if (tick_i) begin
			q_o <= d_i;
		end
	end

endmodule

// ==== logic/mpc_carrier_hyst.sv ====
// Carrier detect with two thresholds; forcing inputs take priority.
module mpc_carrier_hyst (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        force_off_i,
	input  wire logic        force_on_i,
	input  wire logic [15:0] energy_i,
	input  wire logic [15:0] on_level_i,
	input  wire logic [15:0] off_level_i,
	output logic             present_o
);

	wire drop  = present_o && (energy_i < off_level_i);
	wire raise = !present_o && (energy_i > on_level_i);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			present_o <= 1'b0;
		end else if (force_off_i) begin
			present_o <= 1'b0;
		end else if (force_on_i) begin
			present_o <= 1'b1;
		end else if (drop) begin
			present_o <= 1'b0;
		end else if (raise) begin
			present_o <= 1'b1;
		end
	end

endmodule

// ==== logic/mpc_pump_words.sv ====
module mpc_pump_words (
	// Clock and reset
	input  wire logic               CLK_I,
	input  wire logic               RST_I,
	// Host word access
	input  wire logic               RAM_REQ_I,
	input  wire logic               RAM_WE_I,
	input  wire logic [8:0]         RAM_ADDR_I,
	input  wire logic [15:0]        RAM_WDATA_I,
	output logic      [15:0]        RAM_RDATA_O,
	output logic                    RAM_ACK_O,
	// Pump configuration
	input  wire logic [6:0]         MODE_I,
	input  wire logic [2:0]         TXSEQ_I,
	input  wire logic               PARALLEL_XFER_I,
	input  wire logic               BAUD_TICK_I,
	// Signal processing status
	input  wire logic               FIRST_BIQUAD_HIT_I,
	input  wire logic               SECOND_BIQUAD_HIT_I,
	input  wire logic               CASCADE_HIT_I,
	input  wire logic [15:0]        EYE_QUALITY_LEVEL_I,
	input  wire logic [15:0]        LINE_ENERGY_I,
	input  wire logic               RETRAIN_DONE_I,
	input  wire logic               HANDSHAKE_DONE_I,
	input  wire logic [6:0]         NEGOTIATED_MODE_I,
	// Data path
	input  wire logic               TX_HOST_BIT_I,
	input  wire logic               RX_LINE_BIT_I,
	output logic                    TX_LINE_BIT_O,
	output logic                    RX_HOST_BIT_O,
	// Controls to the pump
	output mpc_pkg::mpc_tx_s        TX_CTRL_O,
	output mpc_pkg::mpc_rx_s        RX_CTRL_O,
	output mpc_pkg::mpc_dial_s      DIAL_CTRL_O,
	output mpc_pkg::mpc_dsp_s       DSP_CTRL_O,
	output logic                    EQ_DISCARD_O,
	output logic                    RETRAIN_START_O,
	output logic                    CARRIER_PRESENT_O,
	output logic                    LINE_RELAY_N_O
);

	logic [15:0]          buffer_control;
	logic [15:0]          tone_detect_dial_control;
	logic [15:0]          misc_pump_controls;
	logic [15:0]          modem_control_status;
	logic [15:0]          connection_mode_report;
	logic [15:0]          carrier_on_threshold;
	logic [15:0]          carrier_off_threshold;
	logic [15:0]          eye_quality_max_threshold;
	logic [15:0]          on_applied;
	logic [15:0]          off_applied;
	logic [15:0]          eye_max_applied;
	logic [15:0]          next_modem;
	logic [15:0]          rd_data;
	logic [6:0]           mode_q;
	mpc_pkg::mpc_rt_e     rt_state;
	mpc_pkg::mpc_rt_e     next_rt_state;
	mpc_pkg::mpc_txa_e    tx_action;
	mpc_pkg::mpc_tx_s     next_tx;
	mpc_pkg::mpc_rx_s     next_rx;
	mpc_pkg::mpc_dial_s   next_dial;
	mpc_pkg::mpc_dsp_s    next_dsp;

	// Mode classification.
	wire is_v22fam = (MODE_I == mpc_pkg::MODE_V22BIS) || (MODE_I == mpc_pkg::MODE_V22)
		|| (MODE_I == mpc_pkg::MODE_212);
	wire is_fsk    = (MODE_I == mpc_pkg::MODE_V21) || (MODE_I == mpc_pkg::MODE_103)
		|| (MODE_I == mpc_pkg::MODE_V23_FWD) || (MODE_I == mpc_pkg::MODE_V23_REV);
	wire is_data   = is_v22fam || is_fsk;
	wire is_dial   = (MODE_I == mpc_pkg::MODE_DIAL);
	wire mode_chg  = (MODE_I != mode_q);
	wire enter_data = mode_chg && is_data;
	wire enter_dial = mode_chg && is_dial;

	// Host access decode.
	wire wr          = RAM_REQ_I && RAM_WE_I;
	wire wr_buf      = wr && (RAM_ADDR_I == mpc_pkg::ADDR_BUF);
	wire wr_tone     = wr && (RAM_ADDR_I == mpc_pkg::ADDR_TONE);
	wire wr_misc     = wr && (RAM_ADDR_I == mpc_pkg::ADDR_MISC);
	wire wr_modem    = wr && (RAM_ADDR_I == mpc_pkg::ADDR_MODEM);
	wire wr_cd_on    = wr && (RAM_ADDR_I == mpc_pkg::ADDR_CD_ON);
	wire wr_cd_off   = wr && (RAM_ADDR_I == mpc_pkg::ADDR_CD_OFF);
	wire wr_eye_max  = wr && (RAM_ADDR_I == mpc_pkg::ADDR_EYE_MAX);

	// Retrain only makes sense on a live 2400 bps link.
	wire retrain_go  = (rt_state == mpc_pkg::MPC_RT_IDLE)
		&& modem_control_status[mpc_pkg::MODEM_RETRAIN]
		&& (MODE_I == mpc_pkg::MODE_V22BIS) && !mode_chg;
	wire retrain_end = (rt_state == mpc_pkg::MPC_RT_BUSY) && RETRAIN_DONE_I;

	// Eye-quality compare, only meaningful in V.22-family data modes.
	wire eye_exceeded = is_v22fam && (EYE_QUALITY_LEVEL_I > eye_max_applied);

	always_comb begin
		unique case (rt_state)
			mpc_pkg::MPC_RT_IDLE: begin
				next_rt_state = retrain_go ? mpc_pkg::MPC_RT_BUSY : mpc_pkg::MPC_RT_IDLE;
			end
			mpc_pkg::MPC_RT_BUSY: begin
				next_rt_state = (retrain_end || mode_chg) ? mpc_pkg::MPC_RT_IDLE
					: mpc_pkg::MPC_RT_BUSY;
			end
		endcase
	end

	always_comb begin
		next_modem = wr_modem ? RAM_WDATA_I : modem_control_status;
		if (retrain_go || enter_data) begin
			next_modem[mpc_pkg::MODEM_RETRAIN] = 1'b0;
		end
		if (enter_data || enter_dial) begin
			next_modem[mpc_pkg::MODEM_SEIZE] = 1'b1;
		end
	end

	// Transmit sequence decode for both mode families.
	always_comb begin
		tx_action = mpc_pkg::MPC_TXA_TRAIN;
		if (TXSEQ_I == mpc_pkg::TXSEQ_SILENT) begin
			tx_action = mpc_pkg::MPC_TXA_SILENT;
		end else if (TXSEQ_I == mpc_pkg::TXSEQ_DATA) begin
			tx_action = mpc_pkg::MPC_TXA_DATA;
		end else if (TXSEQ_I == mpc_pkg::TXSEQ_TONE) begin
			tx_action = mpc_pkg::MPC_TXA_TONE;
		end else if (is_v22fam && (TXSEQ_I == mpc_pkg::TXSEQ_DATA_HI)) begin
			tx_action = mpc_pkg::MPC_TXA_DATA;
		end
	end

	always_comb begin
		next_tx.action       = tx_action;
		next_tx.scrambler_on = is_v22fam && !buffer_control[mpc_pkg::BUF_SCR_OFF];
		next_tx.force_marks  = buffer_control[mpc_pkg::BUF_TX_MARKS];
		next_tx.guard_on     = is_v22fam && misc_pump_controls[mpc_pkg::MISC_GUARD_EN];
		next_tx.guard_1800   = misc_pump_controls[mpc_pkg::MISC_GUARD_SEL];
		next_rx.scrambler_on = is_v22fam && !buffer_control[mpc_pkg::BUF_DSCR_OFF];
		next_rx.force_marks  = buffer_control[mpc_pkg::BUF_RX_MARKS];
		next_rx.hdlc         = is_data && PARALLEL_XFER_I && buffer_control[mpc_pkg::BUF_HDLC];
		next_dial.active     = is_dial;
		next_dial.multitone  = is_dial && tone_detect_dial_control[mpc_pkg::TONE_MULTITONE];
		next_dial.timed      = tone_detect_dial_control[mpc_pkg::TONE_TIMED];
		next_dial.digit      = tone_detect_dial_control[3:0];
		next_dsp.cascade     = tone_detect_dial_control[mpc_pkg::TONE_CASCADE];
		next_dsp.squarer_bypass = tone_detect_dial_control[mpc_pkg::TONE_CASCADE]
			&& tone_detect_dial_control[mpc_pkg::TONE_SQR_BYP];
		next_dsp.gain_freeze = is_v22fam && misc_pump_controls[mpc_pkg::MISC_GAIN_FRZ];
		next_dsp.eq_freeze   = misc_pump_controls[mpc_pkg::MISC_EQ_FRZ];
		next_dsp.eq_symbol_spaced = !is_v22fam && misc_pump_controls[mpc_pkg::MISC_SYM_SPACE];
	end

	always_comb begin
		unique case (RAM_ADDR_I)
			mpc_pkg::ADDR_CONN:    rd_data = connection_mode_report;
			mpc_pkg::ADDR_CD_ON:   rd_data = carrier_on_threshold;
			mpc_pkg::ADDR_CD_OFF:  rd_data = carrier_off_threshold;
			mpc_pkg::ADDR_EYE_MAX: rd_data = eye_quality_max_threshold;
			mpc_pkg::ADDR_MODEM:   rd_data = modem_control_status;
			mpc_pkg::ADDR_MISC:    rd_data = misc_pump_controls;
			mpc_pkg::ADDR_TONE:    rd_data = tone_detect_dial_control;
			mpc_pkg::ADDR_BUF:     rd_data = buffer_control;
			default:               rd_data = 16'h0000;
		endcase
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			RAM_ACK_O   <= 1'b0;
			RAM_RDATA_O <= 16'h0000;
		end else begin
			RAM_ACK_O <= RAM_REQ_I;
			if (RAM_REQ_I && !RAM_WE_I) begin
				RAM_RDATA_O <= rd_data;
			end
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			buffer_control            <= mpc_pkg::RST_BUF;
			carrier_on_threshold      <= mpc_pkg::RST_CD_ON;
			carrier_off_threshold     <= mpc_pkg::RST_CD_OFF;
			eye_quality_max_threshold <= mpc_pkg::RST_EYE_MAX;
		end else begin
			if (wr_buf) begin
				buffer_control <= RAM_WDATA_I;
			end
			if (wr_cd_on) begin
				carrier_on_threshold <= RAM_WDATA_I;
			end
			if (wr_cd_off) begin
				carrier_off_threshold <= RAM_WDATA_I;
			end
			if (wr_eye_max) begin
				eye_quality_max_threshold <= RAM_WDATA_I;
			end
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			tone_detect_dial_control <= mpc_pkg::RST_TONE;
		end else begin
			tone_detect_dial_control[mpc_pkg::TONE_A_HIT] <=
				tone_detect_dial_control[mpc_pkg::TONE_CASCADE] ? CASCADE_HIT_I
				: FIRST_BIQUAD_HIT_I;
			tone_detect_dial_control[mpc_pkg::TONE_B_HIT] <= SECOND_BIQUAD_HIT_I;
			if (wr_tone) begin
				tone_detect_dial_control[13:0] <= RAM_WDATA_I[13:0];
			end
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			misc_pump_controls <= mpc_pkg::RST_MISC;
		end else begin
			if (wr_misc) begin
				misc_pump_controls[15:5] <= RAM_WDATA_I[15:5];
				misc_pump_controls[3:0]  <= RAM_WDATA_I[3:0];
			end
			if (!is_v22fam) begin
				misc_pump_controls[mpc_pkg::MISC_EYE_EXC] <= 1'b0;
			end else if (BAUD_TICK_I) begin
				misc_pump_controls[mpc_pkg::MISC_EYE_EXC] <= eye_exceeded;
			end
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			modem_control_status <= mpc_pkg::RST_MODEM;
			rt_state             <= mpc_pkg::MPC_RT_IDLE;
			mode_q               <= mpc_pkg::MODE_STANDBY;
			RETRAIN_START_O      <= 1'b0;
			EQ_DISCARD_O         <= 1'b0;
		end else begin
			modem_control_status <= next_modem;
			rt_state             <= next_rt_state;
			mode_q               <= MODE_I;
			RETRAIN_START_O      <= retrain_go;
			EQ_DISCARD_O         <= mode_chg;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			connection_mode_report <= mpc_pkg::RST_CONN;
		end else if (HANDSHAKE_DONE_I) begin
			connection_mode_report <= {9'h000, NEGOTIATED_MODE_I};
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			TX_CTRL_O      <= '0;
			RX_CTRL_O      <= '0;
			DIAL_CTRL_O    <= '0;
			DSP_CTRL_O     <= '0;
			TX_LINE_BIT_O  <= 1'b1;
			RX_HOST_BIT_O  <= 1'b1;
			LINE_RELAY_N_O <= 1'b1;
		end else begin
			TX_CTRL_O      <= next_tx;
			RX_CTRL_O      <= next_rx;
			DIAL_CTRL_O    <= next_dial;
			DSP_CTRL_O     <= next_dsp;
			TX_LINE_BIT_O  <= TX_HOST_BIT_I || buffer_control[mpc_pkg::BUF_TX_MARKS];
			RX_HOST_BIT_O  <= RX_LINE_BIT_I || buffer_control[mpc_pkg::BUF_RX_MARKS];
			LINE_RELAY_N_O <= !next_modem[mpc_pkg::MODEM_SEIZE];
		end
	end

	mpc_baud_shadow #(
		.RESET_VALUE (mpc_pkg::RST_CD_ON)
	) u_on_shadow (
		.clk_i  (CLK_I),
		.rst_i  (RST_I),
		.tick_i (BAUD_TICK_I),
		.d_i    (carrier_on_threshold),
		.q_o    (on_applied)
	);

	mpc_baud_shadow #(
		.RESET_VALUE (mpc_pkg::RST_CD_OFF)
	) u_off_shadow (
		.clk_i  (CLK_I),
		.rst_i  (RST_I),
		.tick_i (BAUD_TICK_I),
		.d_i    (carrier_off_threshold),
		.q_o    (off_applied)
	);

	mpc_baud_shadow #(
		.RESET_VALUE (mpc_pkg::RST_EYE_MAX)
	) u_eye_shadow (
		.clk_i  (CLK_I),
		.rst_i  (RST_I),
		.tick_i (BAUD_TICK_I),
		.d_i    (eye_quality_max_threshold),
		.q_o    (eye_max_applied)
	);

	mpc_carrier_hyst u_carrier (
		.clk_i       (CLK_I),
		.rst_i       (RST_I),
		.force_off_i (retrain_go || ((rt_state == mpc_pkg::MPC_RT_BUSY) && !RETRAIN_DONE_I)),
		.force_on_i  (retrain_end),
		.energy_i    (LINE_ENERGY_I),
		.on_level_i  (on_applied),
		.off_level_i (off_applied),
		.present_o   (CARRIER_PRESENT_O)
	);

endmodule

// ==== testbench/mpc_pump_words_properties.sv ====
module mpc_pump_words_properties (
	// Clock and reset
	input wire logic		CLK_I,
	input wire logic		RST_I,
	// Observed ports
	input wire logic		RAM_REQ_I,
	input wire logic		RAM_ACK_O,
	input wire logic [6:0]		MODE_I,
	input wire logic [2:0]		TXSEQ_I,
	input wire logic		PARALLEL_XFER_I,
	input wire logic		TX_LINE_BIT_O,
	input wire logic		RX_HOST_BIT_O,
	input wire mpc_pkg::mpc_tx_s	TX_CTRL_O,
	input wire mpc_pkg::mpc_rx_s	RX_CTRL_O,
	input wire mpc_pkg::mpc_dsp_s	DSP_CTRL_O,
	input wire logic		EQ_DISCARD_O,
	input wire logic		RETRAIN_START_O,
	input wire logic		CARRIER_PRESENT_O,
	input wire logic		LINE_RELAY_N_O
);
	timeunit 1ns;
	timeprecision 1ps;

	logic	v22_fam;
	logic	fsk;

	assign v22_fam = MODE_I inside {mpc_pkg::MODE_V22BIS, mpc_pkg::MODE_V22, mpc_pkg::MODE_212};
	assign fsk = MODE_I inside {mpc_pkg::MODE_V21, mpc_pkg::MODE_103, mpc_pkg::MODE_V23_FWD,
		mpc_pkg::MODE_V23_REV};

	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	a_ack_single: assert property (RAM_REQ_I ##1 !RAM_REQ_I |-> RAM_ACK_O ##1 !RAM_ACK_O)
		else $error("ack not a single cycle after request");
	a_tx_marks: assert property (TX_CTRL_O.force_marks |-> TX_LINE_BIT_O)
		else $error("line bit not held at mark");
	a_rx_marks: assert property (RX_CTRL_O.force_marks |-> RX_HOST_BIT_O)
		else $error("host bit not held at mark");
	a_hdlc_gate: assert property (RX_CTRL_O.hdlc |-> $past(PARALLEL_XFER_I))
		else $error("framing on while serial transfer");
	a_seq_tone: assert property (fsk && TXSEQ_I == mpc_pkg::TXSEQ_TONE
		|=> TX_CTRL_O.action == mpc_pkg::MPC_TXA_TONE)
		else $error("sequence seven did not send tone");
	a_seq_data: assert property (fsk && TXSEQ_I == mpc_pkg::TXSEQ_DATA
		|=> TX_CTRL_O.action == mpc_pkg::MPC_TXA_DATA)
		else $error("sequence five did not start data");
	a_guard_family: assert property (TX_CTRL_O.guard_on |-> $past(v22_fam))
		else $error("guard tone outside its modes");
	a_half_spacing: assert property (DSP_CTRL_O.eq_symbol_spaced |-> !$past(v22_fam))
		else $error("symbol spacing in a half-spaced mode");
	a_mode_discard: assert property (MODE_I != $past(MODE_I) |=> EQ_DISCARD_O)
		else $error("no discard after mode change");
	a_retrain_drop: assert property (RETRAIN_START_O
		|-> !CARRIER_PRESENT_O && $past(MODE_I) == mpc_pkg::MODE_V22BIS)
		else $error("retrain start with carrier or wrong mode");
	a_dial_seize: assert property (MODE_I == mpc_pkg::MODE_DIAL && $past(MODE_I) != MODE_I
		|-> ##[1:2] !LINE_RELAY_N_O)
		else $error("relay not closed on dial");

	c_retrain: cover property (RETRAIN_START_O);
	c_hdlc: cover property (RX_CTRL_O.hdlc);
	c_tone: cover property (TX_CTRL_O.action == mpc_pkg::MPC_TXA_TONE);
endmodule

// ==== testbench/mpc_host.sv ====
module mpc_host (
	// Clock
	input wire logic		clk_i,
	// Word port
	output logic			req_o,
	output logic			we_o,
	output logic [8:0]		addr_o,
	output logic [15:0]		wdata_o,
	input wire logic [15:0]		rdata_i,
	input wire logic		ack_i
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		req_o = 1'b0;
		we_o = 1'b0;
		addr_o = 9'h000;
		wdata_o = 16'h0000;
	end

	// The request is a one-cycle pulse.
	// Released lines show the inverse so stale values never match.
	task automatic access(input logic w, input logic [8:0] a, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		@(posedge clk_i);
		req_o <= 1'b1;
		we_o <= w;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		req_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 4);
		q = rdata_i;
	endtask

	task automatic rmw(input logic [8:0] a, input logic [15:0] mask, input logic [15:0] val);
		logic [15:0] old;
		access(1'b0, a, 16'h0000, old);
		access(1'b1, a, (old & ~mask) | (val & mask), old);
	endtask
endmodule

// ==== testbench/mpc_pump_words_test.sv ====
module mpc_pump_words_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic			clk = 1'b0, rst = 1'b1, par = 1'b0, baud = 1'b0;
	logic			hit_a = 1'b0, hit_b = 1'b0, hit_c = 1'b0, rt_done = 1'b0;
	logic			hs_done = 1'b0, tx_bit = 1'b0, rx_bit = 1'b0;
	logic [6:0]		mode = 7'h00, neg = 7'h00;
	logic [2:0]		txseq = 3'h0;
	logic [15:0]		eye = 16'h0000, energy = 16'h0000, q;
	logic			req, we, ack, tx_line, rx_host, discard, rt_start, carrier, relay_n;
	logic [8:0]		addr;
	logic [15:0]		wdata, rdata;
	mpc_pkg::mpc_tx_s	tx_ctrl;
	mpc_pkg::mpc_rx_s	rx_ctrl;
	mpc_pkg::mpc_dial_s	dial;
	mpc_pkg::mpc_dsp_s	dsp;
	int			num_errors = 0, comparisons = 0, cycles = 0;
	logic [8:0]		adrs[8] = '{9'h1F0, 9'h1F4, 9'h1F5, 9'h1F6, 9'h1F7, 9'h1FA, 9'h1FC, 9'h1FD};
	logic [15:0]		rstv[8] = '{16'h0000, 16'h00E8, 16'h0082, 16'h0400, 16'h0000,
		16'h0000, 16'h0080, 16'h0000};
	logic [6:0]		conn[4] = '{7'h08, 7'h09, 7'h0B, 7'h13};

	mpc_pump_words i_mpc_pump_words (
		.CLK_I(clk), .RST_I(rst), .RAM_REQ_I(req), .RAM_WE_I(we), .RAM_ADDR_I(addr),
		.RAM_WDATA_I(wdata), .RAM_RDATA_O(rdata), .RAM_ACK_O(ack), .MODE_I(mode),
		.TXSEQ_I(txseq), .PARALLEL_XFER_I(par), .BAUD_TICK_I(baud),
		.FIRST_BIQUAD_HIT_I(hit_a), .SECOND_BIQUAD_HIT_I(hit_b), .CASCADE_HIT_I(hit_c),
		.EYE_QUALITY_LEVEL_I(eye), .LINE_ENERGY_I(energy), .RETRAIN_DONE_I(rt_done),
		.HANDSHAKE_DONE_I(hs_done), .NEGOTIATED_MODE_I(neg), .TX_HOST_BIT_I(tx_bit),
		.RX_LINE_BIT_I(rx_bit), .TX_LINE_BIT_O(tx_line), .RX_HOST_BIT_O(rx_host),
		.TX_CTRL_O(tx_ctrl), .RX_CTRL_O(rx_ctrl), .DIAL_CTRL_O(dial), .DSP_CTRL_O(dsp),
		.EQ_DISCARD_O(discard), .RETRAIN_START_O(rt_start), .CARRIER_PRESENT_O(carrier),
		.LINE_RELAY_N_O(relay_n));

	mpc_host i_mpc_host (.clk_i(clk), .req_o(req), .we_o(we), .addr_o(addr), .wdata_o(wdata),
		.rdata_i(rdata), .ack_i(ack));

	always #2.5 clk = ~clk;

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			num_errors++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		i_mpc_host.access(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input string what, input logic [8:0] a, input logic [15:0] exp);
		i_mpc_host.access(1'b0, a, 16'h0000, q);
		check(what, q, exp);
	endtask

	// Thresholds move to the comparators only at a baud boundary.
	task automatic baud_tick();
		baud <= 1'b1;
		tick(1);
		baud <= 1'b0;
		tick(3);
	endtask

	initial begin
		tick(12);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			rd_chk("reset word", adrs[i], rstv[i]);
		end
		rd_chk("unmapped", 9'h1F1, 16'h0000);
		wr(mpc_pkg::ADDR_CD_ON, 16'h0100);
		rd_chk("on threshold", mpc_pkg::ADDR_CD_ON, 16'h0100);
		wr(mpc_pkg::ADDR_CONN, 16'hFFFF);
		rd_chk("mode report", mpc_pkg::ADDR_CONN, 16'h0000);
		wr(mpc_pkg::ADDR_BUF, 16'h0005);
		tick(2);
		check("tx marks", 16'(tx_line), 16'h0001);
		check("rx marks", 16'(rx_host), 16'h0001);
		wr(mpc_pkg::ADDR_BUF, 16'h0000);
		tick(2);
		check("tx data", 16'(tx_line), 16'h0000);
		i_mpc_host.rmw(mpc_pkg::ADDR_MISC, 16'h430C, 16'h430C);
		mode <= mpc_pkg::MODE_V22BIS;
		txseq <= mpc_pkg::TXSEQ_DATA_HI;
		tick(3);
		check("guard", 16'({tx_ctrl.guard_on, tx_ctrl.guard_1800}), 16'h0003);
		check("v22 data", 16'(tx_ctrl.action), 16'(mpc_pkg::MPC_TXA_DATA));
		check("dsp", 16'(dsp), 16'h0006);
		check("relay", 16'(relay_n), 16'h0000);
		rd_chk("seize", mpc_pkg::ADDR_MODEM, 16'h0004);
		par <= 1'b1;
		wr(mpc_pkg::ADDR_BUF, 16'h008A);
		tick(2);
		check("rx ctrl", 16'(rx_ctrl), 16'h0001);
		check("tx scrambler", 16'(tx_ctrl.scrambler_on), 16'h0000);
		par <= 1'b0;
		tick(2);
		check("serial framing", 16'(rx_ctrl.hdlc), 16'h0000);
		wr(mpc_pkg::ADDR_BUF, 16'h0000);
		eye <= 16'h0401;
		baud_tick();
		check("rx descrambler on", 16'(rx_ctrl), 16'h0004);
		check("tx scrambler on", 16'(tx_ctrl.scrambler_on), 16'h0001);
		rd_chk("eye over", mpc_pkg::ADDR_MISC, 16'h431C);
		eye <= 16'h0400;
		baud_tick();
		rd_chk("eye at limit", mpc_pkg::ADDR_MISC, 16'h430C);
		energy <= 16'h0101;
		baud_tick();
		check("carrier on", 16'(carrier), 16'h0001);
		energy <= 16'h0090;
		baud_tick();
		check("carrier hold", 16'(carrier), 16'h0001);
		energy <= 16'h0081;
		baud_tick();
		check("carrier off", 16'(carrier), 16'h0000);
		energy <= 16'h0101;
		baud_tick();
		i_mpc_host.rmw(mpc_pkg::ADDR_MODEM, 16'h0800, 16'h0800);
		for (int i = 0; i < 8 && rt_start !== 1'b1; i++) @(posedge clk);
		check("retrain start", 16'(rt_start), 16'h0001);
		check("carrier drop", 16'(carrier), 16'h0000);
		rd_chk("retrain clear", mpc_pkg::ADDR_MODEM, 16'h0004);
		rt_done <= 1'b1;
		tick(1);
		rt_done <= 1'b0;
		tick(2);
		check("carrier back", 16'(carrier), 16'h0001);
		mode <= mpc_pkg::MODE_212;
		tick(3);
		check("guard 212", 16'(tx_ctrl.guard_on), 16'h0001);
		mode <= mpc_pkg::MODE_V21;
		txseq <= mpc_pkg::TXSEQ_DATA;
		tick(3);
		check("fsk data", 16'(tx_ctrl.action), 16'(mpc_pkg::MPC_TXA_DATA));
		check("spacing", 16'(dsp.eq_symbol_spaced), 16'h0001);
		txseq <= mpc_pkg::TXSEQ_TONE;
		tick(3);
		check("fsk tone", 16'(tx_ctrl.action), 16'(mpc_pkg::MPC_TXA_TONE));
		txseq <= mpc_pkg::TXSEQ_DATA_HI;
		tick(3);
		check("fsk seq six", 16'(tx_ctrl.action), 16'(mpc_pkg::MPC_TXA_TRAIN));
		mode <= mpc_pkg::MODE_STANDBY;
		txseq <= mpc_pkg::TXSEQ_SILENT;
		i_mpc_host.rmw(mpc_pkg::ADDR_TONE, 16'h009F, 16'h0095);
		mode <= mpc_pkg::MODE_DIAL;
		tick(3);
		check("tone dial", 16'(dial), 16'h0075);
		i_mpc_host.rmw(mpc_pkg::ADDR_TONE, 16'h0090, 16'h0000);
		tick(2);
		check("pulse dial", 16'(dial), 16'h0045);
		hit_a <= 1'b1;
		tick(2);
		rd_chk("hit a", mpc_pkg::ADDR_TONE, 16'h8005);
		hit_a <= 1'b0;
		hit_b <= 1'b1;
		tick(2);
		rd_chk("hit b", mpc_pkg::ADDR_TONE, 16'h4005);
		hit_a <= 1'b1;
		i_mpc_host.rmw(mpc_pkg::ADDR_TONE, 16'h2020, 16'h2020);
		tick(2);
		rd_chk("cascade idle", mpc_pkg::ADDR_TONE, 16'h6025);
		check("cascade ctrl", 16'({dsp.cascade, dsp.squarer_bypass}), 16'h0003);
		hit_c <= 1'b1;
		tick(2);
		rd_chk("cascade hit", mpc_pkg::ADDR_TONE, 16'hE025);
		foreach (conn[i]) begin
			neg <= conn[i];
			hs_done <= 1'b1;
			tick(1);
			hs_done <= 1'b0;
			rd_chk("connection", mpc_pkg::ADDR_CONN, 16'(conn[i]));
		end
		// A reset in mid-run must reload the words that the host has changed.
		mode <= mpc_pkg::MODE_STANDBY;
		hit_a <= 1'b0;
		hit_b <= 1'b0;
		hit_c <= 1'b0;
		tick(2);
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(2);
		check("relay reset", 16'(relay_n), 16'h0001);
		rd_chk("tone reset", mpc_pkg::ADDR_TONE, 16'h0080);
		rd_chk("misc reset", mpc_pkg::ADDR_MISC, 16'h0000);
		rd_chk("seize reset", mpc_pkg::ADDR_MODEM, 16'h0000);
		give_verdict();
	end
endmodule

bind mpc_pump_words mpc_pump_words_properties i_mpc_pump_words_properties (
	.CLK_I(CLK_I), .RST_I(RST_I), .RAM_REQ_I(RAM_REQ_I), .RAM_ACK_O(RAM_ACK_O),
	.MODE_I(MODE_I), .TXSEQ_I(TXSEQ_I), .PARALLEL_XFER_I(PARALLEL_XFER_I),
	.TX_LINE_BIT_O(TX_LINE_BIT_O), .RX_HOST_BIT_O(RX_HOST_BIT_O), .TX_CTRL_O(TX_CTRL_O),
	.RX_CTRL_O(RX_CTRL_O), .DSP_CTRL_O(DSP_CTRL_O), .EQ_DISCARD_O(EQ_DISCARD_O),
	.RETRAIN_START_O(RETRAIN_START_O), .CARRIER_PRESENT_O(CARRIER_PRESENT_O),
	.LINE_RELAY_N_O(LINE_RELAY_N_O));
